// >>> hw/wdt_defs.svh
// Register offsets, field positions, reset values and counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ************************************************************
// Register offsets (byte addresses, low twelve bits)
// ************************************************************
`define WDT_OFF_LAUNCH      12'h000
`define WDT_OFF_SUBSCRIBE   12'h080
`define WDT_OFF_EXPIRY      12'h100
`define WDT_OFF_PUBLISH     12'h180
`define WDT_OFF_IRQ_SET     12'h304
`define WDT_OFF_IRQ_CLR     12'h308
`define WDT_OFF_RUNNING     12'h400
`define WDT_OFF_REQ_STATE   12'h404
`define WDT_OFF_RELOAD_VAL  12'h504
`define WDT_OFF_SLOT_EN     12'h508
`define WDT_OFF_PAUSE_CFG   12'h50c
`define WDT_OFF_SLOT0       12'h600
`define WDT_SLOT_STRIDE     12'h004

// ************************************************************
// Field positions
// ************************************************************
`define WDT_CFG_SLEEP_BIT   0
`define WDT_CFG_HALT_BIT    3
`define WDT_CHAN_EN_BIT     31
`define WDT_CHAN_IDX_MSB    7

// ************************************************************
// Reset values and constants
// ************************************************************
`define WDT_RELOAD_KEY      32'h6e524635
`define WDT_RELOAD_RESET    32'hffffffff
`define WDT_SLOT_EN_RESET   8'h01
`define WDT_CFG_SLEEP_RESET 1'b1
`define WDT_CFG_HALT_RESET  1'b0
`define WDT_SLOW_CLOCK_HZ   32768
`define WDT_RESET_DELAY     2'd2

`endif

// >>> hw/wdt_pkg.sv
// Types shared by the watchdog modules
package wdt_pkg;

  // Progress of the watchdog reset request after an expiry
  typedef enum logic [2:0] {
    RST_IDLE  = 3'b001,
    RST_DELAY = 3'b010,
    RST_FIRE  = 3'b100
  } reset_phase_e;

endpackage

// >>> hw/slow_tick_gen.sv
// Rising-edge detector turning the slow clock level into one-cycle ticks
`timescale 1ns/10ps
module slow_tick_gen (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic slow_clock,
  output logic      tick
);
  import wdt_pkg::*;

  typedef struct packed {
    logic armed;
    logic prev;
    logic tick;
  } tick_state_s;

  tick_state_s state;
  tick_state_s next_state;

  always_comb begin
    next_state      = state;
    next_state.prev = slow_clock;
    // Prev is not the pin level in the first cycle out of reset: no edge
    next_state.armed = 1'b1;
    next_state.tick  = state.armed & slow_clock & ~state.prev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule // slow_tick_gen

// >>> hw/event_channel_port.sv
// Subscribe selector and publish decoder on the event channel fabric
`timescale 1ns/10ps
module event_channel_port #(
  parameter int CHANNELS = 256,
  parameter int IDX_W    = 8
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                sub_en,
  input  wire logic [IDX_W-1:0]    sub_idx,
  input  wire logic [CHANNELS-1:0] channel_in,
  input  wire logic                pub_en,
  input  wire logic [IDX_W-1:0]    pub_idx,
  input  wire logic                pub_fire,
  output logic                     sub_hit,
  output logic [CHANNELS-1:0]      channel_out
);
  import wdt_pkg::*;

  typedef struct packed {
    logic                hit;
    logic [CHANNELS-1:0] out;
  } chan_state_s;

  chan_state_s state;
  chan_state_s next_state;

  always_comb begin
    next_state     = state;
    next_state.hit = sub_en & channel_in[sub_idx];
    next_state.out = '0;
    if (pub_en && pub_fire) begin
      next_state.out[pub_idx] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sub_hit     = state.hit;
  assign channel_out = state.out;

endmodule // event_channel_port

// >>> hw/lowfreq_countdown_watchdog.sv
// Countdown watchdog with AHB-Lite registers, reload slots and reset request
//
// What this block does
// - Start loads the down-counter with the reload value and sets running.
// - Counter decrements per slow tick; wrapping past zero raises expiry.
// - Period is reload value plus one slow clock cycles.
// - While running without another slow source, force the RC oscillator on.
// - Eight write-only reload slots at word offsets from 0x600.
// - Reload only after key written to every enabled slot.
// - Slot enable register, bit i enables slot i; reset enables slot 0.
// - Request state bit i: enabled and not yet requested; resets to 1.
// - Sleep bit zero pauses counting while the CPU sleeps.
// - Halt bit zero pauses counting while a debugger halts the CPU.
// - Every expiry asserts the watchdog reset request.
// - With the interrupt enabled, reset waits two slow clock cycles.
// - A pending watchdog reset can never be cancelled by software.
// - Once running, writes to reload value, slot enables and config ignored.
// - Any reset stops the watchdog and unlocks its configuration.
// - Running indicator reads one while running, zero otherwise.
// - Writing one to interrupt-set enables; read returns enable state.
// - Writing one to interrupt-clear disables; zero has no effect.
// - Enabled subscription starts the watchdog from the chosen channel.
// - Enabled publication broadcasts expiry on the chosen channel.
// - Reload value is 32 bits, writable before start, in slow cycles.
`timescale 1ns/10ps
`include "wdt_defs.svh"
module lowfreq_countdown_watchdog #(
  parameter int NUM_SLOTS = 8,
  parameter int CHANNELS  = 256
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire logic                slow_clock,
  input  wire logic                cpu_sleeping,
  input  wire logic                cpu_halted,
  input  wire logic                other_lf_source_active,
  input  wire logic [CHANNELS-1:0] channel_in,
  output logic [CHANNELS-1:0]      channel_out,
  output logic                     rc_osc_force_on,
  output logic                     wdt_reset_req,
  output logic                     timeout_irq
);
  import wdt_pkg::*;

  typedef struct packed {
    logic                 running;
    logic [31:0]          count;
    logic [31:0]          reload_value;
    logic [NUM_SLOTS-1:0] slot_en;
    logic [NUM_SLOTS-1:0] slot_req;
    logic                 cfg_sleep;
    logic                 cfg_halt;
    logic                 irq_en;
    logic                 expiry_flag;
    logic                 expiry_pulse;
    logic                 sub_en;
    logic [7:0]           sub_idx;
    logic                 pub_en;
    logic [7:0]           pub_idx;
    reset_phase_e         phase;
    logic [1:0]           delay_cnt;
    logic                 reset_req;
    logic                 osc_on;
    logic                 irq;
    logic                 dp_valid;
    logic                 dp_write;
    logic [11:0]          dp_addr;
    logic [31:0]          rdata;
    logic                 readyout;
  } wdt_state_s;

  wdt_state_s           state;
  wdt_state_s           next_state;
  logic                 tick;
  logic                 sub_hit;
  logic                 wr;
  logic                 wr_key;
  logic [NUM_SLOTS-1:0] slot_hit;
  logic [NUM_SLOTS-1:0] req_all;
  logic                 accept;
  logic                 pause;
  logic                 start;
  logic                 reload;
  logic                 expiry;

  // ************************************************************
  // Address decoding
  // ************************************************************
  function automatic logic [11:0] slot_addr(input int idx);
    slot_addr = 12'(`WDT_OFF_SLOT0 + idx * `WDT_SLOT_STRIDE);
  endfunction

  function automatic logic is_wr(input logic [11:0] off);
    is_wr = state.dp_valid && state.dp_write && (state.dp_addr == off);
  endfunction

  assign wr     = state.dp_valid & state.dp_write;
  assign wr_key = wr & (hwdata == `WDT_RELOAD_KEY);
  assign accept = hsel & hready & htrans[1];

  // One flag per slot; a wrong value or a disabled slot leaves it alone
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    assign slot_hit[g] = wr_key & state.slot_en[g] &
                         (state.dp_addr == slot_addr(g));
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  slow_tick_gen u_tick (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .slow_clock (slow_clock),
    .tick       (tick)
  );

  event_channel_port #(
    .CHANNELS (CHANNELS),
    .IDX_W    (8)
  ) u_chan (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sub_en      (state.sub_en),
    .sub_idx     (state.sub_idx),
    .channel_in  (channel_in),
    .pub_en      (state.pub_en),
    .pub_idx     (state.pub_idx),
    .pub_fire    (state.expiry_pulse),
    .sub_hit     (sub_hit),
    .channel_out (channel_out)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  assign pause   = (cpu_sleeping & ~state.cfg_sleep) |
                   (cpu_halted & ~state.cfg_halt);
  // Written out: a function reading state hides it from this assignment
  assign start   = ~state.running &
                   ((wr & (state.dp_addr == `WDT_OFF_LAUNCH) & hwdata[0]) |
                    sub_hit);
  assign req_all = state.slot_req | slot_hit;
  // Slot hit term keeps an all-disabled enable set from reloading forever
  assign reload  = state.running & (|slot_hit) &
                   ((req_all & state.slot_en) == state.slot_en);
  assign expiry  = state.running & ~reload & tick & ~pause &
                   (state.count == 32'h0);

  always_comb begin
    next_state              = state;
    next_state.readyout     = 1'b1;
    next_state.dp_valid     = accept;
    next_state.dp_write     = hwrite;
    next_state.dp_addr      = haddr[11:0];
    next_state.expiry_pulse = expiry;
    next_state.slot_req     = reload ? '0 : req_all;

    if (start) begin
      next_state.running = 1'b1;
      next_state.count   = state.reload_value;
    end else if (reload) begin
      next_state.count = state.reload_value;
    end else if (state.running && tick && !pause) begin
      next_state.count = state.count - 32'h1;
    end

    // Configuration is locked while running; reset unlocks it again
    if (!state.running) begin
      if (is_wr(`WDT_OFF_RELOAD_VAL)) begin
        next_state.reload_value = hwdata;
      end
      if (is_wr(`WDT_OFF_SLOT_EN)) begin
        next_state.slot_en = hwdata[NUM_SLOTS-1:0];
      end
      if (is_wr(`WDT_OFF_PAUSE_CFG)) begin
        next_state.cfg_sleep = hwdata[`WDT_CFG_SLEEP_BIT];
        next_state.cfg_halt  = hwdata[`WDT_CFG_HALT_BIT];
      end
    end

    if (is_wr(`WDT_OFF_SUBSCRIBE)) begin
      next_state.sub_en  = hwdata[`WDT_CHAN_EN_BIT];
      next_state.sub_idx = hwdata[`WDT_CHAN_IDX_MSB:0];
    end
    if (is_wr(`WDT_OFF_PUBLISH)) begin
      next_state.pub_en  = hwdata[`WDT_CHAN_EN_BIT];
      next_state.pub_idx = hwdata[`WDT_CHAN_IDX_MSB:0];
    end
    if (is_wr(`WDT_OFF_IRQ_SET) && hwdata[0]) begin
      next_state.irq_en = 1'b1;
    end
    if (is_wr(`WDT_OFF_IRQ_CLR) && hwdata[0]) begin
      next_state.irq_en = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (is_wr(`WDT_OFF_EXPIRY)) begin
      next_state.expiry_flag = hwdata[0];
    end
    if (expiry) begin
      next_state.expiry_flag = 1'b1;
    end
    next_state.irq = next_state.expiry_flag & next_state.irq_en;

    // Nothing but hresetn leaves the fire phase
    case (state.phase)
      RST_IDLE: begin
        if (expiry && state.irq_en) begin
          next_state.phase     = RST_DELAY;
          next_state.delay_cnt = 2'd0;
        end else if (expiry) begin
          next_state.phase = RST_FIRE;
        end
      end
      RST_DELAY: begin
        if (tick) begin
          next_state.delay_cnt = state.delay_cnt + 2'd1;
          if (state.delay_cnt == `WDT_RESET_DELAY - 2'd1) begin
            next_state.phase = RST_FIRE;
          end
        end
      end
      RST_FIRE: begin
        next_state.phase = RST_FIRE;
      end
      default: begin
        next_state.phase = RST_FIRE;
      end
    endcase
    next_state.reset_req = (next_state.phase == RST_FIRE);
    next_state.osc_on    = next_state.running &
                           ~other_lf_source_active;

    // Read data is prepared in the address phase for a zero-wait answer
    next_state.rdata = '0;
    if (accept && !hwrite) begin
      case (haddr[11:0])
        `WDT_OFF_SUBSCRIBE: begin
          next_state.rdata[`WDT_CHAN_EN_BIT]     = state.sub_en;
          next_state.rdata[`WDT_CHAN_IDX_MSB:0]  = state.sub_idx;
        end
        `WDT_OFF_PUBLISH: begin
          next_state.rdata[`WDT_CHAN_EN_BIT]     = state.pub_en;
          next_state.rdata[`WDT_CHAN_IDX_MSB:0]  = state.pub_idx;
        end
        `WDT_OFF_EXPIRY: begin
          next_state.rdata[0] = state.expiry_flag;
        end
        `WDT_OFF_IRQ_SET, `WDT_OFF_IRQ_CLR: begin
          next_state.rdata[0] = state.irq_en;
        end
        `WDT_OFF_RUNNING: begin
          next_state.rdata[0] = state.running;
        end
        `WDT_OFF_REQ_STATE: begin
          next_state.rdata[NUM_SLOTS-1:0] =
            state.slot_en & ~state.slot_req;
        end
        `WDT_OFF_RELOAD_VAL: begin
          next_state.rdata = state.reload_value;
        end
        `WDT_OFF_SLOT_EN: begin
          next_state.rdata[NUM_SLOTS-1:0] = state.slot_en;
        end
        `WDT_OFF_PAUSE_CFG: begin
          next_state.rdata[`WDT_CFG_SLEEP_BIT] = state.cfg_sleep;
          next_state.rdata[`WDT_CFG_HALT_BIT]  = state.cfg_halt;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state              <= '0;
      state.reload_value <= `WDT_RELOAD_RESET;
      state.slot_en      <= NUM_SLOTS'(`WDT_SLOT_EN_RESET);
      state.cfg_sleep    <= `WDT_CFG_SLEEP_RESET;
      state.cfg_halt     <= `WDT_CFG_HALT_RESET;
      state.phase        <= RST_IDLE;
      state.readyout     <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout       = state.readyout;
  assign hrdata          = state.rdata;
  assign hresp           = 1'b0;
  assign rc_osc_force_on = state.osc_on;
  assign wdt_reset_req   = state.reset_req;
  assign timeout_irq     = state.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_START_LOADS: assert property (
    start |=> state.running && state.count == $past(state.reload_value))
    else $error("start did not load the counter");
  AST_DECREMENT: assert property (
    state.running && tick && !pause && !reload
    |=> state.count == $past(state.count) - 32'h1)
    else $error("counter did not decrement on a slow tick");
  AST_WRAP_EXPIRY: assert property (
    expiry |=> state.expiry_pulse && state.expiry_flag &&
               state.count == 32'hffffffff)
    else $error("wrap did not raise expiry");
  AST_OSC_FORCE: assert property (
    ##1 rc_osc_force_on ==
        (state.running && !$past(other_lf_source_active)))
    else $error("oscillator force does not follow running state");
  AST_KEY_RELOAD: assert property (
    reload |=> state.slot_req == '0 &&
               state.count == $past(state.reload_value))
    else $error("reload did not restore the counter");
  AST_PAUSE_HOLD: assert property (
    state.running && pause && !reload |=> state.count == $past(state.count))
    else $error("counter moved while paused");
  AST_NO_DELAY: assert property (
    expiry && !state.irq_en |=> wdt_reset_req)
    else $error("reset request missing after expiry");
  AST_DELAYED: assert property (
    expiry && state.irq_en |=> !wdt_reset_req ##1 !wdt_reset_req)
    else $error("reset was not postponed");
  AST_STICKY: assert property (
    wdt_reset_req |=> wdt_reset_req)
    else $error("pending reset was cancelled");
  AST_LOCKED: assert property (
    state.running |=> state.reload_value == $past(state.reload_value) &&
                      state.slot_en == $past(state.slot_en))
    else $error("configuration changed while running");
  AST_REQ_STATE: assert property (
    accept && !hwrite && haddr[11:0] == `WDT_OFF_REQ_STATE
    |=> hrdata == 32'(state.slot_en & ~state.slot_req) || reload ||
        $past(wr))
    else $error("request state read back wrong");

  COV_START: cover property (start);
  COV_RELOAD: cover property (reload);
  COV_DELAYED_FIRE: cover property (
    state.phase == RST_DELAY ##1 state.phase == RST_FIRE);

endmodule // lowfreq_countdown_watchdog

// >>> sim/slow_osc_model.sv
// Slow RC oscillator model that runs only while some party requests it
`timescale 1ns/10ps
module slow_osc_model #(
  parameter int HALF = 381
) (
  input  wire logic hclk,
  input  wire logic force_on,
  input  wire logic other_on,
  output logic      slow_clock
);
  int cnt = 0;

  initial slow_clock = 1'b0;

  // Stands still without a request, so a dropped force-on stops the count
  always @(posedge hclk) begin
    if (force_on || other_on) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        slow_clock <= ~slow_clock;
      end
    end
  end
endmodule // slow_osc_model

// >>> sim/tb.sv
// Self-checking testbench of the countdown watchdog
`timescale 1ns/10ps
`include "wdt_defs.svh"
module tb;
  localparam int P = 762;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
  } row_s;

  logic         hclk      = 1'b0;
  logic         hresetn   = 1'b0;
  logic         hsel      = 1'b0;
  logic [31:0]  haddr     = 32'h0;
  logic [1:0]   htrans    = 2'h0;
  logic         hwrite    = 1'b0;
  logic [31:0]  hwdata    = 32'h0;
  logic         sleeping  = 1'b0;
  logic         halted    = 1'b0;
  logic         other_src = 1'b0;
  logic [255:0] chan_in   = '0;
  logic         hreadyout;
  logic         hresp;
  logic         slow_clock;
  logic         rc_on;
  logic         rst_req;
  logic         irq;
  logic [31:0]  hrdata;
  logic [255:0] chan_out;
  int           error_cnt       = 0;
  int           samples_checked = 0;
  int           cycles          = 0;
  int           pub_cnt         = 0;
  int           t0;

  row_s rows [23] = '{
    '{1'b0, `WDT_OFF_RUNNING, 32'h0}, '{1'b0, `WDT_OFF_REQ_STATE, 32'h1},
    '{1'b0, `WDT_OFF_RELOAD_VAL, 32'hffffffff},
    '{1'b0, `WDT_OFF_SLOT_EN, 32'h1}, '{1'b0, `WDT_OFF_PAUSE_CFG, 32'h1},
    '{1'b0, `WDT_OFF_IRQ_SET, 32'h0}, '{1'b0, `WDT_OFF_SUBSCRIBE, 32'h0},
    '{1'b0, `WDT_OFF_PUBLISH, 32'h0}, '{1'b0, `WDT_OFF_EXPIRY, 32'h0},
    '{1'b1, `WDT_OFF_RELOAD_VAL, 32'h3}, '{1'b0, `WDT_OFF_RELOAD_VAL, 32'h3},
    '{1'b1, `WDT_OFF_SLOT_EN, 32'h3}, '{1'b0, `WDT_OFF_REQ_STATE, 32'h3},
    '{1'b1, `WDT_OFF_IRQ_SET, 32'h1}, '{1'b0, `WDT_OFF_IRQ_SET, 32'h1},
    '{1'b1, `WDT_OFF_IRQ_CLR, 32'h0}, '{1'b0, `WDT_OFF_IRQ_SET, 32'h1},
    '{1'b1, `WDT_OFF_IRQ_CLR, 32'h1}, '{1'b0, `WDT_OFF_IRQ_SET, 32'h0},
    '{1'b1, `WDT_OFF_PAUSE_CFG, 32'h0}, '{1'b0, `WDT_OFF_PAUSE_CFG, 32'h0},
    '{1'b1, 12'h7fc, 32'hffffffff}, '{1'b0, 12'h7fc, 32'h0}
  };

  always #20 hclk = ~hclk;

  lowfreq_countdown_watchdog DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .slow_clock(slow_clock), .cpu_sleeping(sleeping),
    .cpu_halted(halted), .other_lf_source_active(other_src),
    .channel_in(chan_in), .channel_out(chan_out),
    .rc_osc_force_on(rc_on), .wdt_reset_req(rst_req), .timeout_irq(irq)
  );

  slow_osc_model osc (
    .hclk(hclk), .force_on(rc_on), .other_on(other_src),
    .slow_clock(slow_clock)
  );

  // ************************************************************
  // Monitors and bus tasks
  // ************************************************************
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      finish_test();
    end
  end

  // A pulse on any channel but the published one weighs as a failure
  always @(negedge hclk) begin
    if (chan_out !== '0) begin
      pub_cnt <= pub_cnt + ((chan_out === (256'h1 << 7)) ? 1 : 100);
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    @(negedge hclk);
    chk({31'h0, g}, {31'h0, e});
    @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic feed();
    wr(`WDT_OFF_SLOT0, `WDT_RELOAD_KEY);
    wr(`WDT_OFF_SLOT0 + `WDT_SLOT_STRIDE, `WDT_RELOAD_KEY);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic end_test(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rdx(rows[i].a, rows[i].d);
      end
    end
    end_test("registers");
    wr(`WDT_OFF_LAUNCH, 32'h1);
    rdx(`WDT_OFF_RUNNING, 32'h1);
    chk1(rc_on, 1'b1);
    other_src <= 1'b1;
    repeat (3) @(posedge hclk);
    chk1(rc_on, 1'b0);
    other_src <= 1'b0;
    wr(`WDT_OFF_RELOAD_VAL, 32'h5);
    rdx(`WDT_OFF_RELOAD_VAL, 32'h3);
    wr(`WDT_OFF_SLOT_EN, 32'hff);
    rdx(`WDT_OFF_SLOT_EN, 32'h3);
    wr(`WDT_OFF_PAUSE_CFG, 32'h9);
    rdx(`WDT_OFF_PAUSE_CFG, 32'h0);
    wr(`WDT_OFF_SLOT0, 32'h12345678);
    rdx(`WDT_OFF_REQ_STATE, 32'h3);
    wr(`WDT_OFF_SLOT0, `WDT_RELOAD_KEY);
    rdx(`WDT_OFF_REQ_STATE, 32'h2);
    wr(`WDT_OFF_SLOT0 + `WDT_SLOT_STRIDE, `WDT_RELOAD_KEY);
    rdx(`WDT_OFF_REQ_STATE, 32'h3);
    for (int i = 0; i < 4; i++) begin
      repeat (2 * P) @(posedge hclk);
      feed();
    end
    chk1(rst_req, 1'b0);
    sleeping <= 1'b1;
    repeat (6 * P) @(posedge hclk);
    chk1(rst_req, 1'b0);
    sleeping <= 1'b0;
    feed();
    halted <= 1'b1;
    repeat (6 * P) @(posedge hclk);
    chk1(rst_req, 1'b0);
    halted <= 1'b0;
    feed();
    t0 = cycles;
    do @(negedge hclk); while (rst_req !== 1'b1 && cycles - t0 < 6 * P);
    @(posedge hclk);
    chk1(cycles - t0 >= 3 * P && cycles - t0 <= 4 * P + 8, 1'b1);
    chk1(irq, 1'b0);
    rdx(`WDT_OFF_EXPIRY, 32'h1);
    wr(`WDT_OFF_EXPIRY, 32'h0);
    chk1(rst_req, 1'b1);
    chk(pub_cnt, 0);
    end_test("feed_pause_expiry");
    do_reset();
    chk1(rst_req, 1'b0);
    rdx(`WDT_OFF_RUNNING, 32'h0);
    rdx(`WDT_OFF_RELOAD_VAL, 32'hffffffff);
    wr(`WDT_OFF_RELOAD_VAL, 32'h0);
    wr(`WDT_OFF_IRQ_SET, 32'h1);
    wr(`WDT_OFF_SUBSCRIBE, 32'h80000005);
    wr(`WDT_OFF_PUBLISH, 32'h80000007);
    chan_in[5] <= 1'b1;
    @(posedge hclk);
    chan_in[5] <= 1'b0;
    repeat (3) @(posedge hclk);
    rdx(`WDT_OFF_RUNNING, 32'h1);
    t0 = cycles;
    do @(negedge hclk); while (irq !== 1'b1 && cycles - t0 < 3 * P);
    t0 = cycles;
    chk(rst_req, 1'b0);
    @(posedge hclk);
    // Clearing the event must not call off the pending reset
    wr(`WDT_OFF_EXPIRY, 32'h0);
    do @(negedge hclk); while (rst_req !== 1'b1 && cycles - t0 < 3 * P);
    @(posedge hclk);
    chk1(cycles - t0 >= 2 * P - 4 && cycles - t0 <= 2 * P + 4, 1'b1);
    chk(pub_cnt, 1);
    end_test("irq_delay_events");
    finish_test();
  end
endmodule // tb
